// ===== src/exec_pkg.sv
package exec_pkg;

  // operation select codes, one-hot except OP_NONE, which is all zero
  typedef enum logic [7:0] {
    OP_NONE        = 8'h00,
    OP_RETURN      = 8'h01,
    OP_HALT        = 8'h02,
    OP_LIT_SUB     = 8'h04,
    OP_LIT_XOR     = 8'h08,
    OP_FILE_SUB    = 8'h10,
    OP_FILE_XOR    = 8'h20,
    OP_NIBBLE_SWAP = 8'h40
  } op_t;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_RET2   = 4'h2,
    ST_SLEEP  = 4'h4,
    ST_UNUSED = 4'h8
  } state_t;

  typedef struct packed {
    logic carry;
    logic half_borrow_flag;
    logic zero;
  } flags_t;

  typedef struct packed {
    logic       valid;
    op_t        op;
    logic [7:0] literal;
    logic [6:0] file_addr;
    logic       dest;
  } instr_t;

  localparam int          DATA_W         = 8;
  localparam int          ADDR_W         = 7;
  localparam int          PC_W           = 13;
  localparam int          STACK_DEPTH    = 8;
  localparam logic [7:0]  ACC_RESET      = 8'h00;
  localparam logic [7:0]  WATCHDOG_CLEAR = 8'h00;
  localparam logic        DEST_ACC       = 1'b0;
  localparam logic        DEST_FILE      = 1'b1;
  localparam int          RETURN_CYCLES  = 2;
  localparam int          NIBBLE_LO      = 0;
  localparam int          NIBBLE_HI      = 4;

endpackage

// ===== src/sub_unit.sv
`timescale 1ns/1ps
module sub_unit #(
  parameter int W = 8
) (
  // operands
  input  wire logic [W-1:0] minuend,
  input  wire logic [W-1:0] subtrahend,
  // result
  output logic [W-1:0]      diff,
  output exec_pkg::flags_t  flags
);
  logic [W:0] full;
  logic [4:0] low;

  assign full = {1'b0, minuend} - {1'b0, subtrahend};
  assign low  = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
  assign diff = full[W-1:0];
  // no borrow means carry set
  assign flags = {~full[W], ~low[4], (full[W-1:0] == '0)};
endmodule

// ===== src/return_stack.sv
`timescale 1ns/1ps
module return_stack #(
  parameter int DEPTH = 8,
  parameter int PCW   = 13
) (
  // clock and reset
  input  wire logic           clk,
  input  wire logic           resetn,
  // push from call logic outside
  input  wire logic           push,
  input  wire logic [PCW-1:0] push_pc,
  // pop
  input  wire logic           pop,
  output logic [PCW-1:0]      stack_head
);
  localparam int PW = $clog2(DEPTH);
  logic [PCW-1:0] mem [DEPTH];
  logic [PW-1:0]  ptr_reg;

  // circular, as the hardware stack wraps on overflow
  assign stack_head = mem[PW'(ptr_reg - 1'b1)];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ptr_reg <= '0;
    end else if (push) begin
      ptr_reg <= PW'(ptr_reg + 1'b1);
    end else if (pop) begin
      ptr_reg <= PW'(ptr_reg - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[ptr_reg] <= push_pc;
    end
  end
endmodule

// ===== src/exec_group.sv
// Operation
// - return pops stack into pc, two cycles
// - halt clears powerdown bit, sets expiry bit
// - halt clears watchdog count and prescaler
// - halt enters sleep, oscillator stopped, no issue
// - literal minus acc into acc, C DC Z
// - literal xor acc into acc, Z only
// - file minus acc, C DC Z
// - file xor acc, Z only
// - nibble exchange of file, no flags
// - dest 0 to acc, 1 to file
`timescale 1ns/1ps
module exec_group #(
  parameter int STACK_DEPTH = exec_pkg::STACK_DEPTH,
  parameter int PC_W        = exec_pkg::PC_W
) (
  // clock and reset
  input  wire logic                            clk,
  input  wire logic                            resetn,
  // instruction issue
  input  wire exec_pkg::instr_t                instr,
  output logic                                 issue_ready,
  // file register access
  input  wire logic [exec_pkg::DATA_W-1:0]     file_rdata,
  output logic [exec_pkg::ADDR_W-1:0]          file_addr,
  output logic                                 file_we,
  output logic [exec_pkg::DATA_W-1:0]          file_wdata,
  // stack push from call logic
  input  wire logic                            stack_push,
  input  wire logic [PC_W-1:0]                 stack_push_pc,
  // program counter load
  output logic                                 pc_load,
  output logic [PC_W-1:0]                      pc_value,
  // accumulator and status
  output logic [exec_pkg::DATA_W-1:0]          acc_reg,
  output exec_pkg::flags_t                     flags_reg,
  output logic                                 powerdown_bit,
  output logic                                 expiry_status_bit,
  // watchdog and oscillator control
  output logic                                 watchdog_clear,
  output logic                                 prescaler_clear,
  output logic                                 osc_stop,
  // wake from sleep, from the wake-up logic outside
  input  wire logic                            wake
);
  exec_pkg::state_t          state_reg;
  exec_pkg::state_t          state_next;
  logic [exec_pkg::DATA_W-1:0] sub_a;
  logic [exec_pkg::DATA_W-1:0] sub_res;
  exec_pkg::flags_t            sub_flags;
  logic [exec_pkg::DATA_W-1:0] result;
  logic [PC_W-1:0]             head;
  logic                        take;
  logic                        is_file_op;
  logic                        writes_flags_full;
  logic                        writes_zero;

  assign take = instr.valid && issue_ready;
  assign is_file_op = instr.op inside {exec_pkg::OP_FILE_SUB, exec_pkg::OP_FILE_XOR,
                                       exec_pkg::OP_NIBBLE_SWAP};
  assign file_addr = instr.file_addr;

  // one subtractor shared by both subtract forms
  assign sub_a = (instr.op == exec_pkg::OP_LIT_SUB) ? instr.literal : file_rdata;

  sub_unit #(
    .W (exec_pkg::DATA_W)
  ) u_sub (
    .minuend    (sub_a),
    .subtrahend (acc_reg),
    .diff       (sub_res),
    .flags      (sub_flags)
  );

  return_stack #(
    .DEPTH (STACK_DEPTH),
    .PCW   (PC_W)
  ) u_stack (
    .clk        (clk),
    .resetn     (resetn),
    .push       (stack_push),
    .push_pc    (stack_push_pc),
    .pop        (take && instr.op == exec_pkg::OP_RETURN),
    .stack_head (head)
  );

  always_comb begin
    result            = acc_reg;
    writes_flags_full = 1'b0;
    writes_zero       = 1'b0;
    case (instr.op)
      exec_pkg::OP_LIT_SUB, exec_pkg::OP_FILE_SUB: begin
        result            = sub_res;
        writes_flags_full = 1'b1;
      end
      exec_pkg::OP_LIT_XOR: begin
        result      = acc_reg ^ instr.literal;
        writes_zero = 1'b1;
      end
      exec_pkg::OP_FILE_XOR: begin
        result      = acc_reg ^ file_rdata;
        writes_zero = 1'b1;
      end
      exec_pkg::OP_NIBBLE_SWAP: begin
        result = {file_rdata[exec_pkg::NIBBLE_LO +: 4], file_rdata[exec_pkg::NIBBLE_HI +: 4]};
      end
      default: begin
        result = acc_reg;
      end
    endcase
  end

  // sequencer
  assign issue_ready = (state_reg == exec_pkg::ST_IDLE);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      exec_pkg::ST_IDLE: begin
        if (take && instr.op == exec_pkg::OP_RETURN) begin
          state_next = exec_pkg::ST_RET2;
        end else if (take && instr.op == exec_pkg::OP_HALT) begin
          state_next = exec_pkg::ST_SLEEP;
        end
      end
      exec_pkg::ST_RET2: begin
        state_next = exec_pkg::ST_IDLE;
      end
      exec_pkg::ST_SLEEP: begin
        if (wake) begin
          state_next = exec_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = exec_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= exec_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // program counter load in the second return cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pc_load  <= 1'b0;
      pc_value <= '0;
    end else begin
      pc_load <= take && instr.op == exec_pkg::OP_RETURN;
      if (take && instr.op == exec_pkg::OP_RETURN) begin
        pc_value <= head;
      end
    end
  end

  // accumulator and file write
  // write address is not held here: the file side latches file_addr at issue
  always_ff @(posedge clk) begin
    if (!resetn) begin
      acc_reg    <= exec_pkg::ACC_RESET;
      file_we    <= 1'b0;
      file_wdata <= '0;
    end else begin
      file_we <= 1'b0;
      if (take && (instr.op == exec_pkg::OP_LIT_SUB || instr.op == exec_pkg::OP_LIT_XOR)) begin
        acc_reg <= result;
      end else if (take && is_file_op) begin
        if (instr.dest == exec_pkg::DEST_FILE) begin
          file_we    <= 1'b1;
          file_wdata <= result;
        end else begin
          acc_reg <= result;
        end
      end
    end
  end

  // flags: return, halt and swap leave them alone
  always_ff @(posedge clk) begin
    if (!resetn) begin
      flags_reg <= '0;
    end else if (take && writes_flags_full) begin
      flags_reg <= sub_flags;
    end else if (take && writes_zero) begin
      flags_reg.zero <= (result == '0);
    end
  end

  // power status, active-low bits idle high
  always_ff @(posedge clk) begin
    if (!resetn) begin
      powerdown_bit     <= 1'b1;
      expiry_status_bit <= 1'b1;
    end else if (take && instr.op == exec_pkg::OP_HALT) begin
      powerdown_bit     <= 1'b0;
      expiry_status_bit <= 1'b1;
    end
  end

  // watchdog clear is a pulse for the external counter
  always_ff @(posedge clk) begin
    if (!resetn) begin
      watchdog_clear  <= 1'b0;
      prescaler_clear <= 1'b0;
    end else begin
      watchdog_clear  <= take && instr.op == exec_pkg::OP_HALT;
      prescaler_clear <= take && instr.op == exec_pkg::OP_HALT;
    end
  end

  assign osc_stop = (state_reg == exec_pkg::ST_SLEEP);

  a_return_two_cycles: assert property (@(posedge clk) disable iff (!resetn)
    take && instr.op == exec_pkg::OP_RETURN |=> !issue_ready && pc_load ##1 issue_ready)
    else $error("return did not take two cycles");
  a_return_pc_head: assert property (@(posedge clk) disable iff (!resetn)
    take && instr.op == exec_pkg::OP_RETURN |=> pc_value == $past(head))
    else $error("pc not loaded from stack head");
  a_halt_status: assert property (@(posedge clk) disable iff (!resetn)
    take && instr.op == exec_pkg::OP_HALT |=> !powerdown_bit && expiry_status_bit)
    else $error("halt status bits wrong");
  a_halt_watchdog: assert property (@(posedge clk) disable iff (!resetn)
    take && instr.op == exec_pkg::OP_HALT |=> watchdog_clear && prescaler_clear)
    else $error("watchdog not cleared on halt");
  a_sleep_no_issue: assert property (@(posedge clk) disable iff (!resetn)
    osc_stop |=> $stable(acc_reg) && $stable(flags_reg) && !file_we && !pc_load)
    else $error("work done while asleep");
  a_lit_sub_acc: assert property (@(posedge clk) disable iff (!resetn)
    take && instr.op == exec_pkg::OP_LIT_SUB |=>
      acc_reg == 8'($past(instr.literal) - $past(acc_reg)) && flags_reg.zero == (acc_reg == 8'h00))
    else $error("literal subtract wrong");
  a_lit_xor_acc: assert property (@(posedge clk) disable iff (!resetn)
    take && instr.op == exec_pkg::OP_LIT_XOR |=>
      acc_reg == ($past(instr.literal) ^ $past(acc_reg)) && flags_reg.carry == $past(flags_reg.carry))
    else $error("literal xor wrong");
  a_file_sub_carry: assert property (@(posedge clk) disable iff (!resetn)
    take && instr.op == exec_pkg::OP_FILE_SUB |=> flags_reg.carry == ($past(file_rdata) >= $past(acc_reg)))
    else $error("file subtract carry wrong");
  a_file_xor_flags: assert property (@(posedge clk) disable iff (!resetn)
    take && instr.op == exec_pkg::OP_FILE_XOR |=> flags_reg.half_borrow_flag == $past(flags_reg.half_borrow_flag))
    else $error("file xor touched digit flag");
  a_swap_result: assert property (@(posedge clk) disable iff (!resetn)
    take && instr.op == exec_pkg::OP_NIBBLE_SWAP && instr.dest |=>
      file_wdata == {$past(file_rdata[3:0]), $past(file_rdata[7:4])} && flags_reg == $past(flags_reg))
    else $error("nibble exchange wrong");
  a_dest_select: assert property (@(posedge clk) disable iff (!resetn)
    take && is_file_op && instr.dest == exec_pkg::DEST_ACC |=> !file_we)
    else $error("file written with dest 0");
  a_half_borrow: assert property (@(posedge clk) disable iff (!resetn)
    take && instr.op == exec_pkg::OP_FILE_SUB |=>
      flags_reg.half_borrow_flag == ($past(file_rdata[3:0]) >= $past(acc_reg[3:0])))
    else $error("digit flag wrong");

  // data values and what must stay put
  a_return_flags: assert property (@(posedge clk) disable iff (!resetn)
    take && instr.op == exec_pkg::OP_RETURN |=> flags_reg == $past(flags_reg) && acc_reg == $past(acc_reg))
    else $error("return touched flags or acc");
  a_pc_load_pulse: assert property (@(posedge clk) disable iff (!resetn)
    pc_load |=> !pc_load)
    else $error("pc load longer than one cycle");
  a_halt_keeps_data: assert property (@(posedge clk) disable iff (!resetn)
    take && instr.op == exec_pkg::OP_HALT |=> flags_reg == $past(flags_reg) && acc_reg == $past(acc_reg))
    else $error("halt touched flags or acc");
  a_clear_pulse: assert property (@(posedge clk) disable iff (!resetn)
    watchdog_clear |=> !watchdog_clear && !prescaler_clear)
    else $error("watchdog clear longer than one cycle");
  a_sleep_until_wake: assert property (@(posedge clk) disable iff (!resetn)
    osc_stop && !wake |=> osc_stop)
    else $error("left sleep without wake");
  a_lit_sub_flags: assert property (@(posedge clk) disable iff (!resetn)
    take && instr.op == exec_pkg::OP_LIT_SUB |=>
      flags_reg.carry == ($past(instr.literal) >= $past(acc_reg))
      && flags_reg.half_borrow_flag == ($past(instr.literal[3:0]) >= $past(acc_reg[3:0])))
    else $error("literal subtract flags wrong");
  a_file_sub_value: assert property (@(posedge clk) disable iff (!resetn)
    take && instr.op == exec_pkg::OP_FILE_SUB && instr.dest == exec_pkg::DEST_FILE |=>
      file_we && file_wdata == 8'($past(file_rdata) - $past(acc_reg)))
    else $error("file subtract result wrong");
  a_file_xor_value: assert property (@(posedge clk) disable iff (!resetn)
    take && instr.op == exec_pkg::OP_FILE_XOR && instr.dest == exec_pkg::DEST_ACC |=>
      acc_reg == ($past(acc_reg) ^ $past(file_rdata)) && flags_reg.zero == (acc_reg == 8'h00))
    else $error("file xor result wrong");
  a_swap_to_acc: assert property (@(posedge clk) disable iff (!resetn)
    take && instr.op == exec_pkg::OP_NIBBLE_SWAP && instr.dest == exec_pkg::DEST_ACC |=>
      acc_reg == {$past(file_rdata[3:0]), $past(file_rdata[7:4])} && !file_we)
    else $error("nibble exchange to acc wrong");
  a_none_no_effect: assert property (@(posedge clk) disable iff (!resetn)
    take && instr.op == exec_pkg::OP_NONE |=>
      !file_we && acc_reg == $past(acc_reg) && flags_reg == $past(flags_reg))
    else $error("empty operation had an effect");
  a_sub_zero_flag: assert property (@(posedge clk) disable iff (!resetn)
    take && instr.op == exec_pkg::OP_FILE_SUB && instr.dest == exec_pkg::DEST_FILE |=>
      flags_reg.zero == (file_wdata == 8'h00))
    else $error("subtract zero flag wrong");

  c_return: cover property (@(posedge clk) take && instr.op == exec_pkg::OP_RETURN);
  c_sleep_wake: cover property (@(posedge clk) osc_stop ##1 wake);
  c_sub_zero: cover property (@(posedge clk) take && instr.op == exec_pkg::OP_FILE_SUB ##1 flags_reg.zero);
  c_swap_file: cover property (@(posedge clk) take && instr.op == exec_pkg::OP_NIBBLE_SWAP && instr.dest);
  c_halt_take: cover property (@(posedge clk) take && instr.op == exec_pkg::OP_HALT);
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic                                 clk;
  logic                                 resetn;
  exec_pkg::instr_t                     instr;
  logic                                 issue_ready;
  logic [exec_pkg::DATA_W-1:0]          file_rdata;
  logic [exec_pkg::ADDR_W-1:0]          file_addr;
  logic                                 file_we;
  logic [exec_pkg::DATA_W-1:0]          file_wdata;
  logic                                 stack_push;
  logic [exec_pkg::PC_W-1:0]            stack_push_pc;
  logic                                 pc_load;
  logic [exec_pkg::PC_W-1:0]            pc_value;
  logic [exec_pkg::DATA_W-1:0]          acc_reg;
  exec_pkg::flags_t                     flags_reg;
  logic                                 powerdown_bit;
  logic                                 expiry_status_bit;
  logic                                 watchdog_clear;
  logic                                 prescaler_clear;
  logic                                 osc_stop;
  logic                                 wake;
  int                                   errors;
  int                                   comparisons;
  int                                   cycles;
  logic [7:0]                           acc_m;
  logic [2:0]                           flags_m;

  exec_group exec_group_i (
    .clk               (clk),
    .resetn            (resetn),
    .instr             (instr),
    .issue_ready       (issue_ready),
    .file_rdata        (file_rdata),
    .file_addr         (file_addr),
    .file_we           (file_we),
    .file_wdata        (file_wdata),
    .stack_push        (stack_push),
    .stack_push_pc     (stack_push_pc),
    .pc_load           (pc_load),
    .pc_value          (pc_value),
    .acc_reg           (acc_reg),
    .flags_reg         (flags_reg),
    .powerdown_bit     (powerdown_bit),
    .expiry_status_bit (expiry_status_bit),
    .watchdog_clear    (watchdog_clear),
    .prescaler_clear   (prescaler_clear),
    .osc_stop          (osc_stop),
    .wake              (wake)
  );

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic close_out;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // caller sits just after a rising edge; model tracks acc and flags
  // valid is left high so calls chain with no double drive in one step
  task automatic run(input exec_pkg::op_t op, input logic [7:0] lit, input logic [7:0] rd,
                     input logic [6:0] fa, input logic d);
    logic [7:0] a;
    logic [7:0] res;
    logic       wr;
    instr.valid     = 1'h1;
    instr.op        = op;
    instr.literal   = lit;
    instr.file_addr = fa;
    instr.dest      = d;
    file_rdata      = rd;
    wr              = 1'h0;
    a               = (op == exec_pkg::OP_LIT_SUB || op == exec_pkg::OP_LIT_XOR) ? lit : rd;
    #1 check("file_addr", file_addr, fa);
    case (op)
      exec_pkg::OP_LIT_SUB, exec_pkg::OP_FILE_SUB: begin
        res     = a - acc_m;
        flags_m = {a >= acc_m, a[3:0] >= acc_m[3:0], res == 8'h00};
      end
      exec_pkg::OP_LIT_XOR, exec_pkg::OP_FILE_XOR: begin
        res        = a ^ acc_m;
        flags_m[0] = (res == 8'h00);
      end
      exec_pkg::OP_NIBBLE_SWAP: res = {rd[3:0], rd[7:4]};
      default: res = acc_m;
    endcase
    if (op == exec_pkg::OP_LIT_SUB || op == exec_pkg::OP_LIT_XOR || (op != exec_pkg::OP_NONE && d == 1'h0)) begin
      acc_m = res;
    end else if (op != exec_pkg::OP_NONE) begin
      wr = 1'h1;
    end
    @(posedge clk);
    #1 check("acc_reg", acc_reg, acc_m);
    check("flags_reg", flags_reg, flags_m);
    check("file_we", file_we, wr);
    if (wr) begin
      check("file_wdata", file_wdata, res);
    end
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      close_out();
    end
  end

  initial begin
    errors        = 0;
    comparisons   = 0;
    cycles        = 0;
    acc_m         = 8'h00;
    flags_m       = 3'h0;
    resetn        = 1'h0;
    instr         = '0;
    file_rdata    = 8'h00;
    stack_push    = 1'h0;
    stack_push_pc = 13'h0000;
    wake          = 1'h0;
    repeat (10) @(posedge clk);
    #1 resetn = 1'h1;
    check("acc_reset", acc_reg, 8'h00);
    check("status_reset", {powerdown_bit, expiry_status_bit, issue_ready, osc_stop}, 4'hE);
    run(exec_pkg::OP_LIT_XOR, 8'h3C, 8'h00, 7'h00, 1'h0);
    run(exec_pkg::OP_LIT_XOR, 8'h3C, 8'h00, 7'h00, 1'h0);
    run(exec_pkg::OP_LIT_XOR, 8'h05, 8'h00, 7'h00, 1'h0);
    run(exec_pkg::OP_LIT_SUB, 8'h03, 8'h00, 7'h00, 1'h0);
    run(exec_pkg::OP_LIT_SUB, 8'hFE, 8'h00, 7'h00, 1'h0);
    run(exec_pkg::OP_LIT_XOR, 8'h11, 8'h00, 7'h00, 1'h0);
    run(exec_pkg::OP_FILE_SUB, 8'h00, 8'h30, 7'h7F, 1'h1);
    run(exec_pkg::OP_FILE_SUB, 8'h00, 8'h10, 7'h00, 1'h0);
    run(exec_pkg::OP_FILE_XOR, 8'h00, 8'hFF, 7'h2A, 1'h0);
    run(exec_pkg::OP_FILE_XOR, 8'h00, 8'hA5, 7'h55, 1'h1);
    run(exec_pkg::OP_NIBBLE_SWAP, 8'h00, 8'hA5, 7'h01, 1'h1);
    run(exec_pkg::OP_NIBBLE_SWAP, 8'h00, 8'h3C, 7'h7E, 1'h0);
    run(exec_pkg::OP_NONE, 8'hFF, 8'hFF, 7'h00, 1'h1);
    // two pushes, then two returns back to back pop in reverse order
    instr.valid   = 1'h0;
    stack_push    = 1'h1;
    stack_push_pc = 13'h0ABC;
    @(posedge clk);
    #1 stack_push_pc = 13'h1234;
    @(posedge clk);
    #1 stack_push = 1'h0;
    for (int i = 0; i < 2; i++) begin
      instr.valid = 1'h1;
      instr.op    = exec_pkg::OP_RETURN;
      @(posedge clk);
      #1 instr.valid = 1'h0;
      check("pc_load", pc_load, 1'h1);
      check("pc_value", pc_value, (i == 0) ? 13'h1234 : 13'h0ABC);
      check("ret_busy", issue_ready, 1'h0);
      check("ret_flags", flags_reg, flags_m);
      @(posedge clk);
      #1 check("ret_done", {issue_ready, pc_load}, 2'h2);
    end
    instr.valid = 1'h1;
    instr.op    = exec_pkg::OP_HALT;
    @(posedge clk);
    #1 instr.op = exec_pkg::OP_LIT_XOR;
    instr.literal = 8'hFF;
    check("halt_status", {powerdown_bit, expiry_status_bit}, 2'h1);
    check("halt_clears", {watchdog_clear, prescaler_clear}, 2'h3);
    check("halt_sleep", {osc_stop, issue_ready}, 2'h2);
    @(posedge clk);
    #1 check("clear_pulse", {watchdog_clear, prescaler_clear}, 2'h0);
    // an offered instruction must not be taken while asleep
    repeat (3) @(posedge clk);
    #1 instr.valid = 1'h0;
    check("sleep_acc", acc_reg, acc_m);
    check("sleep_osc", {osc_stop, issue_ready}, 2'h2);
    wake = 1'h1;
    @(posedge clk);
    #1 wake = 1'h0;
    check("woken", {osc_stop, issue_ready, powerdown_bit}, 3'h2);
    run(exec_pkg::OP_LIT_XOR, 8'h0F, 8'h00, 7'h00, 1'h0);
    close_out();
  end
endmodule
